/* bench/flash_cmd_seq_chk.sv */
// Concurrent checks on the ports of the flash command sequencer
`timescale 1ns/1ps
module flash_cmd_seq_chk #(
  parameter TW_CYCLES = 20
) (
  input wire        clk,
  input wire        reset_n,
  input wire        ce,
  input wire        sclk,
  input wire        cs_n,
  input wire [3:0]  io_in,
  input wire [3:0]  io_out,
  input wire [3:0]  io_oe,
  input wire        ext_busy,
  input wire        ext_done,
  input wire        mem_req,
  input wire [23:0] mem_addr,
  input wire [7:0]  mem_rdata,
  input wire        mem_rdata_valid,
  input wire        mem_rdata_ready,
  input wire [15:0] status_word,
  input wire        crm_active
);
  // ***************************************************************
  // Helper logic and sequences
  // ***************************************************************
  // Busy span is a parameter, so it is counted rather than repeated
  reg [31:0] busy_cnt_reg;
  always @(posedge clk) begin
    if (!reset_n || !status_word[0]) begin
      busy_cnt_reg <= 32'h0;
    end else if (ce) begin
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence cs_idle;
    cs_n [*6];
  endsequence
  sequence done_then_settle;
    ext_done ##2 1'b1;
  endsequence
  reset_values_a: assert property ($rose(reset_n) |-> io_oe == 4'h0 && status_word == 16'h0 && !crm_active)
    else $error("outputs not at reset values");
  bus_released_a: assert property (cs_idle |-> io_oe == 4'h0)
    else $error("data lines driven while deselected");
  top_bit_zero_a: assert property (status_word[15] == 1'b0)
    else $error("status bit 15 set");
  req_pulse_a: assert property (mem_req |=> !mem_req until (mem_rdata_valid && mem_rdata_ready))
    else $error("second fetch before reply");
  req_answer_a: assert property (mem_req |-> ##[1:4] (mem_rdata_valid && mem_rdata_ready))
    else $error("fetch reply not taken");
  addr_step_a: assert property (mem_req |=> mem_addr == $past(mem_addr) + 24'h1)
    else $error("fetch address did not advance");
  busy_needs_latch_a: assert property ($rose(status_word[0]) |-> status_word[1])
    else $error("write cycle started without latch");
  busy_end_a: assert property ($fell(status_word[0]) |-> !status_word[1]
    && busy_cnt_reg >= TW_CYCLES - 1 && busy_cnt_reg <= TW_CYCLES + 1)
    else $error("write cycle length or latch wrong");
  done_clears_a: assert property (done_then_settle |-> !status_word[1])
    else $error("latch survived completion");
  quad_gate_a: assert property (io_oe[3] |-> status_word[9])
    else $error("quad output without quad enable");
  oe_shape_a: assert property (io_oe != 4'h0 |-> io_oe == 4'h2 || io_oe == 4'h3 || io_oe == 4'hf)
    else $error("illegal output enable pattern");
endmodule // flash_cmd_seq_chk
bind flash_cmd_seq flash_cmd_seq_chk #(.TW_CYCLES(TW_CYCLES)) chk (.clk(clk), .reset_n(reset_n),
  .ce(ce), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .ext_busy(ext_busy), .ext_done(ext_done), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid), .mem_rdata_ready(mem_rdata_ready),
  .status_word(status_word), .crm_active(crm_active));

/* bench/spi_host_model.sv */
// Behavioural SPI host that frames commands towards the sequencer
`timescale 1ns/1ps
module spi_host_model (
  input  wire       clk,
  input  wire [3:0] io_out,
  input  wire [3:0] io_oe,
  output reg        sclk,
  output reg        cs_n,
  output reg  [3:0] io_in,
  output reg  [7:0] got_byte,
  output reg        got_flag
);
  reg [3:0] drv;
  reg [3:0] en;
  reg [3:0] last;
  reg       wp_n;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    drv = 4'h0;
    en = 4'h4;
    last = 4'h0;
    wp_n = 1'b1;
    got_byte = 8'h00;
    got_flag = 1'b0;
  end
  // Undriven lines show the inverse of their last level, so stale data never matches
  always @* begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = io_oe[i] ? io_out[i] : (en[i] ? (i == 2 ? wp_n : drv[i]) : ~last[i]);
    end
  end
  always @(posedge clk) begin
    last <= io_in;
  end
  // Clock idles high; a frame opens with select falling
  task start();
    cs_n = 1'b0;
    #80;
  endtask
  task stop();
    #40 cs_n = 1'b1;
    en = 4'h4;
    #300;
  endtask
  // Shifts nc clocks on ln lanes, top bits first; on receive, lines released before the first fall
  task xfer(input [7:0] b, input int ln, input int nc, input bit rx);
    reg [7:0] sh;
    sh = b;
    en = rx ? (ln == 4 ? 4'h0 : 4'h4) : (ln == 1 ? 4'h5 : 4'h7);
    for (int k = 0; k < nc; k++) begin
      sclk = 1'b0;
      if (!rx && ln == 1) drv[0] = sh[7];
      if (!rx && ln == 2) drv[1:0] = sh[7:6];
      #80 sclk = 1'b1;
      #70;
      sh = sh << ln;
      if (rx) sh = sh | (ln == 1 ? {7'h0, io_in[1]} : ln == 2 ? {6'h0, io_in[1:0]} : {4'h0, io_in});
      #10;
    end
    if (rx) begin
      got_byte = sh;
      got_flag = ~got_flag;
    end
  endtask
endmodule // spi_host_model

/* bench/tb_top.sv */
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module tb_top;
  localparam TW = 400;
  reg         clk, reset_n, ext_busy, ext_done, mem_rdata_valid, quiet;
  reg  [7:0]  mem_rdata, lo, hi, d;
  reg  [23:0] a;
  wire        sclk, cs_n, mem_req, mem_rdata_ready, crm_active, got_flag;
  wire [3:0]  io_in, io_out, io_oe;
  wire [23:0] mem_addr;
  wire [15:0] status_word;
  wire [7:0]  got_byte;
  reg  [7:0]  exp_q[$];
  int         err_total, checks_done, reqs;
  flash_cmd_seq #(.TW_CYCLES(TW)) uut (.clk(clk), .reset_n(reset_n), .ce(1'b1), .sclk(sclk),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .ext_busy(ext_busy),
    .ext_done(ext_done), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_rdata_valid(mem_rdata_valid), .mem_rdata_ready(mem_rdata_ready),
    .status_word(status_word), .crm_active(crm_active));
  spi_host_model host (.clk(clk), .io_out(io_out), .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in), .got_byte(got_byte), .got_flag(got_flag));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function [7:0] pat(input [23:0] x);
    pat = x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3c;
  endfunction
  // Memory answers one clock after each fetch and holds until taken
  always @(posedge clk) begin
    if (mem_rdata_valid && mem_rdata_ready) mem_rdata_valid <= #1 1'b0;
    if (mem_req) begin
      mem_rdata <= #1 pat(mem_addr);
      mem_rdata_valid <= #1 1'b1;
      reqs <= reqs + 1;
    end
  end
  task chk(input string n, input [7:0] e, input [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Oldest note is compared against every byte the host captures while quiet is clear
  // Start after time zero so the flag's first settling is not taken as a byte
  initial begin
    #1;
    forever begin
      @(got_flag);
      if (!quiet) chk("read byte", exp_q.size() ? exp_q.pop_front() : ~got_byte, got_byte);
    end
  end
  task test_done();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmd(input [7:0] op);
    host.start();
    host.xfer(op, 1, 8, 0);
    host.stop();
  endtask
  task rd_status(input [7:0] op, input [7:0] e);
    exp_q.push_back(e);
    exp_q.push_back(e);
    host.start();
    host.xfer(op, 1, 8, 0);
    host.xfer(8'h00, 1, 8, 1);
    host.xfer(8'h00, 1, 8, 1);
    host.stop();
  endtask
  // kind 1 arms the latch, kind 2 the volatile path; nb data bits then select rises
  task wr_status(input int kind, input int nb, input [7:0] l, input [7:0] h);
    if (kind == 1) cmd(`OP_WRITE_ENABLE);
    if (kind == 2) cmd(`OP_VOLATILE_ENABLE);
    host.start();
    host.xfer(`OP_STATUS_WRITE, 1, 8, 0);
    host.xfer(l, 1, 8, 0);
    if (nb > 8) host.xfer(h, 1, nb - 8, 0);
    host.stop();
    for (int i = 0; i < 2 * TW && status_word[0]; i++) @(posedge clk);
  endtask
  task rd_mem(input [7:0] op, input int li, input int lo_n, input bit opc, input [7:0] mode);
    a = $urandom;
    if (!quiet) exp_q.push_back(pat(a));
    if (!quiet) exp_q.push_back(pat(a + 24'h1));
    host.start();
    if (opc) host.xfer(op, 1, 8, 0);
    for (int i = 2; i >= 0; i--) host.xfer(a[8*i +: 8], li, 8 / li, 0);
    if (op != `OP_READ) host.xfer(mode, li, 8 / li, 0);
    host.xfer(8'h00, lo_n, 8 / lo_n, 1);
    host.xfer(8'h00, lo_n, 8 / lo_n, 1);
    host.stop();
  endtask
  initial begin
    #1500000;
    err_total++;
    test_done();
  end
  initial begin
    {reset_n, ext_busy, ext_done, mem_rdata_valid, quiet} = 5'h0;
    mem_rdata = 8'h00;
    {err_total, checks_done, reqs} = 0;
    void'($urandom(42074));
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge clk);
    rd_status(`OP_STATUS_READ_LO, 8'h00);
    rd_status(`OP_STATUS_READ_HI, 8'h00);
    cmd(`OP_WRITE_ENABLE);
    rd_status(`OP_STATUS_READ_LO, 8'h02);
    cmd(`OP_WRITE_DISABLE);
    rd_status(`OP_STATUS_READ_LO, 8'h00);
    lo = $urandom;
    hi = ($urandom & 8'hfe) | 8'h02;
    wr_status(0, 16, lo, hi);
    rd_status(`OP_STATUS_READ_LO, 8'h00);
    cmd(`OP_WRITE_ENABLE);
    host.start();
    host.xfer(`OP_STATUS_WRITE, 1, 8, 0);
    host.xfer(lo, 1, 8, 0);
    host.xfer(hi, 1, 8, 0);
    host.stop();
    rd_status(`OP_STATUS_READ_LO, 8'h03);
    for (int i = 0; i < 2 * TW && status_word[0]; i++) @(posedge clk);
    rd_status(`OP_STATUS_READ_LO, {lo[7:2], 2'b00});
    rd_status(`OP_STATUS_READ_HI, {1'b0, hi[6:0]});
    rd_mem(`OP_READ, 1, 1, 1, 8'h00);
    rd_mem(`OP_FAST_READ, 1, 1, 1, 8'h00);
    rd_mem(`OP_DUAL_OUT_READ, 1, 2, 1, 8'h00);
    rd_mem(`OP_QUAD_OUT_READ, 1, 4, 1, 8'h00);
    rd_mem(`OP_DUAL_IO_READ, 2, 2, 1, ($urandom & 8'hcf) | 8'h20);
    chk("continuous mode", 8'h01, {7'h0, crm_active});
    rd_mem(`OP_DUAL_IO_READ, 2, 2, 0, $urandom & 8'hcf);
    chk("continuous mode", 8'h00, {7'h0, crm_active});
    rd_status(`OP_STATUS_READ_LO, {lo[7:2], 2'b00});
    ext_busy = 1'b1;
    quiet = 1'b1;
    reqs = 0;
    rd_mem(`OP_READ, 1, 1, 1, 8'h00);
    quiet = 1'b0;
    ext_busy = 1'b0;
    chk("fetch count", 8'h00, reqs[7:0]);
    cmd(`OP_WRITE_ENABLE);
    @(posedge clk) #1 ext_done = 1'b1;
    @(posedge clk) #1 ext_done = 1'b0;
    rd_status(`OP_STATUS_READ_LO, {lo[7:2], 2'b00});
    wr_status(1, 12, 8'hff, 8'hff);
    rd_status(`OP_STATUS_READ_LO, {lo[7:2], 2'b10});
    cmd(`OP_WRITE_DISABLE);
    d = $urandom;
    wr_status(1, 8, d, 8'h00);
    rd_status(`OP_STATUS_READ_LO, {d[7:2], 2'b00});
    rd_status(`OP_STATUS_READ_HI, {1'b0, hi[6:2], 2'b00});
    wr_status(2, 8, 8'h80, 8'h00);
    rd_status(`OP_STATUS_READ_LO, 8'h80);
    host.wp_n = 1'b0;
    wr_status(1, 16, 8'h00, 8'h00);
    rd_status(`OP_STATUS_READ_LO, 8'h82);
    host.wp_n = 1'b1;
    wr_status(1, 16, 8'h00, 8'h00);
    rd_status(`OP_STATUS_READ_LO, 8'h00);
    chk("notes left", 8'h00, exp_q.size());
    test_done();
  end
endmodule // tb_top

/* rtl/byte_skid_buffer.v */
// Two-entry valid/ready buffer between memory read data and the shifter
`timescale 1ns/1ps
module byte_skid_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             ce,
  input  wire             flush,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] slot0_reg;
  reg [WIDTH-1:0] slot1_reg;
  reg [1:0]       count_reg;
  reg [1:0]       count_next;
  wire            push;
  wire            pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot0_reg;

  // Occupancy; ready is registered so the source sees a clean flop
  always @* begin
    count_next = count_reg;
    if (flush)
      count_next = 2'h0;
    else if (push & ~pop)
      count_next = count_reg + 2'h1;
    else if (pop & ~push)
      count_next = count_reg - 2'h1;
  end

  // Slot 0 is always the head; slot 1 only holds the second word
  always @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= 2'h0;
      in_ready  <= 1'b0;
      slot0_reg <= {WIDTH{1'b0}};
      slot1_reg <= {WIDTH{1'b0}};
    end else if (ce) begin
      count_reg <= count_next;
      in_ready  <= (count_next != 2'h2);
      if (pop) begin
        slot0_reg <= (count_reg == 2'h2) ? slot1_reg : in_data;
        if (push && count_reg == 2'h2)
          slot1_reg <= in_data;
      end else if (push) begin
        if (count_reg == 2'h0)
          slot0_reg <= in_data;
        else
          slot1_reg <= in_data;
      end
    end
  end

endmodule // byte_skid_buffer

/* rtl/flash_cmd_seq.v */
// Serial flash status and read command sequencer
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_cmd_seq #(
  parameter TW_CYCLES = `STATUS_WRITE_CYCLES
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        ce,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire [3:0]  io_in,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe,
  input  wire        ext_busy,
  input  wire        ext_done,
  output reg         mem_req,
  output reg  [23:0] mem_addr,
  input  wire [7:0]  mem_rdata,
  input  wire        mem_rdata_valid,
  output wire        mem_rdata_ready,
  output reg  [15:0] status_word,
  output reg         crm_active
);

  // ***************************************************************
  // Frame states
  // ***************************************************************
  localparam ST_IDLE  = 4'h0;
  localparam ST_CMD   = 4'h1;
  localparam ST_ADDR  = 4'h2;
  localparam ST_MODE  = 4'h3;
  localparam ST_DUMMY = 4'h4;
  localparam ST_DOUT  = 4'h5;
  localparam ST_SROUT = 4'h6;
  localparam ST_SRIN  = 4'h7;
  localparam ST_SINK  = 4'h8;

  localparam [23:0] TW_LAST = TW_CYCLES[23:0] - 24'h000001;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  reg [5:0]  pin_s1_reg;
  reg [5:0]  pin_s2_reg;
  reg [5:0]  pin_s3_reg;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_fall;
  wire       cs_rise;
  wire       cs_low;
  wire [3:0] io_s;

  // Three stages; an edge counts once stages two and three disagree
  always @(posedge clk) begin
    if (!reset_n) begin
      pin_s1_reg <= 6'h3f;
      pin_s2_reg <= 6'h3f;
      pin_s3_reg <= 6'h3f;
    end else if (ce) begin
      pin_s1_reg <= {sclk, cs_n, io_in};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign sclk_rise = pin_s2_reg[5] & ~pin_s3_reg[5];
  assign sclk_fall = ~pin_s2_reg[5] & pin_s3_reg[5];
  assign cs_fall   = ~pin_s2_reg[4] & pin_s3_reg[4];
  assign cs_rise   = pin_s2_reg[4] & ~pin_s3_reg[4];
  assign cs_low    = ~pin_s3_reg[4];
  assign io_s      = pin_s2_reg[3:0];

  // ***************************************************************
  // Sequencer registers
  // ***************************************************************
  reg [3:0]  state_reg;
  reg [4:0]  cnt_reg;
  reg [23:0] shin_reg;
  reg        dual_in_reg;
  reg [1:0]  lanes_reg;
  reg        fast_reg;
  reg        mode_reg;
  reg        hi_sel_reg;
  reg [7:0]  shout_reg;
  reg [2:0]  units_reg;
  reg        wel_reg;
  reg        wip_reg;
  reg [23:0] tw_cnt_reg;
  reg [12:0] nv_reg;
  reg [12:0] vol_reg;
  reg [12:0] pend_reg;
  reg        vol_arm_reg;
  reg        vol_use_reg;
  reg        sr_ok_reg;
  reg        fetch_reg;
  reg        pending_reg;
  reg        drop_reg;
  wire [15:0] status_now;
  wire [7:0]  opcode;
  wire [1:0]  in_bits;
  wire [23:0] shin_next;
  wire        hw_protect;
  wire        buf_valid;
  wire [7:0]  buf_data;
  wire        buf_pop;
  wire        buf_flush;
  wire [7:0]  out_src;
  wire [7:0]  out_cur;
  wire [12:0] wr_bits;

  // Live status word; bit 15 is reserved and reads zero
  assign status_now = {1'b0, vol_reg, wel_reg, wip_reg};

  // Serial input takes line zero; dual input takes line one high
  assign in_bits   = dual_in_reg ? io_s[1:0] : {1'b0, io_s[0]};
  assign shin_next = dual_in_reg ? {shin_reg[21:0], in_bits}
                                 : {shin_reg[22:0], in_bits[0]};
  assign opcode    = shin_next[7:0];

  // Hardware lock: lower protect set, upper clear, protect pin low
  assign hw_protect = ~vol_reg[`SR_STATUS_PROTECT_UPPER-2] & vol_reg[`SR_STATUS_PROTECT_LOWER-2] & ~io_s[2];

  // Eight data bits clear quad enable and upper protect; with sixteen the
  // low status byte arrived first and sits one byte up in the shifter
  assign wr_bits = (cnt_reg == 5'd8)
                 ? {vol_reg[12:8], 2'b00, shin_reg[7:2]}
                 : {shin_reg[6:0], shin_reg[15:10]};

  // Output byte: memory data in reads, the chosen status byte otherwise
  assign out_src = (state_reg == ST_SROUT)
                 ? (hi_sel_reg ? status_now[15:8] : status_now[7:0])
                 : (buf_valid ? buf_data : 8'h00);
  assign out_cur = (units_reg == 3'd0) ? out_src : shout_reg;
  assign buf_pop = ce & sclk_fall & (state_reg == ST_DOUT) & (units_reg == 3'd0);
  assign buf_flush = cs_rise;

  // ***************************************************************
  // Command state machine
  // ***************************************************************
  always @(posedge clk) begin
    if (!reset_n) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 5'd0;
      shin_reg    <= 24'h000000;
      dual_in_reg <= 1'b0;
      lanes_reg   <= 2'd0;
      fast_reg    <= 1'b0;
      mode_reg    <= 1'b0;
      hi_sel_reg  <= 1'b0;
      shout_reg   <= 8'h00;
      units_reg   <= 3'd0;
      wel_reg     <= 1'b0;
      wip_reg     <= 1'b0;
      tw_cnt_reg  <= 24'h000000;
      nv_reg      <= `SR_NV_RESET;
      vol_reg     <= `SR_NV_RESET;
      pend_reg    <= 13'h0000;
      vol_arm_reg <= 1'b0;
      vol_use_reg <= 1'b0;
      sr_ok_reg   <= 1'b0;
      fetch_reg   <= 1'b0;
      crm_active  <= 1'b0;
      io_out      <= 4'h0;
      io_oe       <= 4'h0;
      status_word <= 16'h0000;
      mem_addr    <= 24'h000000;
    end else if (ce) begin
      status_word <= status_now;
      // Completions clear the latch first so a same-cycle set still wins
      if (ext_done)
        wel_reg <= 1'b0;
      if (wip_reg) begin
        if (tw_cnt_reg == 24'h000000) begin
          wip_reg <= 1'b0;
          wel_reg <= 1'b0;
          nv_reg  <= pend_reg;
          vol_reg <= pend_reg;
        end else
          tw_cnt_reg <= tw_cnt_reg - 24'h000001;
      end
      if (mem_req)
        mem_addr <= mem_addr + 24'h000001;

      if (cs_rise) begin
        // Frame end: decide a status write, release lines, stop fetching
        if (state_reg == ST_SRIN && sr_ok_reg &&
            (cnt_reg == 5'd8 || cnt_reg == 5'd16)) begin
          if (vol_use_reg)
            vol_reg <= wr_bits;
          else begin
            pend_reg   <= wr_bits;
            wip_reg    <= 1'b1;
            tw_cnt_reg <= TW_LAST;
          end
        end
        state_reg <= ST_IDLE;
        io_oe     <= 4'h0;
        fetch_reg <= 1'b0;
      end else if (cs_fall) begin
        // Continuous mode enters straight at the dual address
        cnt_reg     <= 5'd0;
        units_reg   <= 3'd0;
        dual_in_reg <= crm_active;
        lanes_reg   <= crm_active ? 2'd1 : 2'd0;
        fast_reg    <= 1'b0;
        mode_reg    <= crm_active;
        state_reg   <= crm_active ? ST_ADDR : ST_CMD;
      end else if (sclk_rise && cs_low) begin
        shin_reg <= shin_next;
        cnt_reg  <= cnt_reg + (dual_in_reg ? 5'd2 : 5'd1);
        case (state_reg)
          ST_CMD: begin
            if (cnt_reg == 5'd7) begin
              cnt_reg   <= 5'd0;
              state_reg <= ST_SINK;
              case (opcode)
                `OP_WRITE_ENABLE:    wel_reg <= 1'b1;
                `OP_WRITE_DISABLE:   wel_reg <= 1'b0;
                `OP_VOLATILE_ENABLE: vol_arm_reg <= 1'b1;
                `OP_STATUS_READ_LO, `OP_STATUS_READ_HI: begin
                  hi_sel_reg <= (opcode == `OP_STATUS_READ_HI);
                  state_reg  <= ST_SROUT;
                end
                `OP_STATUS_WRITE: begin
                  // Volatile arm is spent by this write whatever happens
                  vol_use_reg <= vol_arm_reg;
                  vol_arm_reg <= 1'b0;
                  sr_ok_reg   <= (wel_reg | vol_arm_reg) & ~hw_protect
                                 & ~wip_reg;
                  state_reg   <= ST_SRIN;
                end
                `OP_READ: begin
                  if (!(wip_reg | ext_busy))
                    state_reg <= ST_ADDR;
                end
                `OP_FAST_READ: begin
                  fast_reg  <= 1'b1;
                  state_reg <= ST_ADDR;
                end
                `OP_DUAL_OUT_READ: begin
                  fast_reg  <= 1'b1;
                  lanes_reg <= 2'd1;
                  state_reg <= ST_ADDR;
                end
                `OP_QUAD_OUT_READ: begin
                  // Quad lanes carry the protect pin, so quad needs enable
                  fast_reg  <= 1'b1;
                  lanes_reg <= 2'd2;
                  if (vol_reg[`SR_QE-2])
                    state_reg <= ST_ADDR;
                end
                `OP_DUAL_IO_READ: begin
                  dual_in_reg <= 1'b1;
                  lanes_reg   <= 2'd1;
                  mode_reg    <= 1'b1;
                  state_reg   <= ST_ADDR;
                end
                default: state_reg <= ST_SINK;
              endcase
            end
          end
          ST_ADDR: begin
            if (cnt_reg == (dual_in_reg ? 5'd22 : 5'd23)) begin
              cnt_reg   <= 5'd0;
              mem_addr  <= shin_next;
              fetch_reg <= 1'b1;
              state_reg <= mode_reg ? ST_MODE : (fast_reg ? ST_DUMMY : ST_DOUT);
            end
          end
          ST_MODE: begin
            if (cnt_reg == 5'd6) begin
              crm_active <= (shin_next[5:4] == `CRM_ENTER_CODE);
              state_reg  <= ST_DOUT;
            end
          end
          ST_DUMMY: begin
            if (cnt_reg == 5'd7)
              state_reg <= ST_DOUT;
          end
          ST_SRIN: begin
            // Saturate past sixteen so an overlong write stays invalid
            if (cnt_reg == 5'd17)
              cnt_reg <= 5'd17;
          end
          default: cnt_reg <= 5'd0;
        endcase
      end else if (sclk_fall && cs_low &&
                   (state_reg == ST_DOUT || state_reg == ST_SROUT)) begin
        // Drive on falling edges, MSB group first on the active lanes
        case (lanes_reg)
          2'd1: begin
            io_out    <= {2'b00, out_cur[7:6]};
            io_oe     <= 4'h3;
            shout_reg <= {out_cur[5:0], 2'b00};
            units_reg <= (units_reg == 3'd0) ? 3'd3 : units_reg - 3'd1;
          end
          2'd2: begin
            io_out    <= out_cur[7:4];
            io_oe     <= 4'hf;
            shout_reg <= {out_cur[3:0], 4'h0};
            units_reg <= (units_reg == 3'd0) ? 3'd1 : units_reg - 3'd1;
          end
          default: begin
            io_out    <= {2'b00, out_cur[7], 1'b0};
            io_oe     <= 4'h2;
            shout_reg <= {out_cur[6:0], 1'b0};
            units_reg <= (units_reg == 3'd0) ? 3'd7 : units_reg - 3'd1;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Memory fetch, one request outstanding at a time
  // ***************************************************************
  wire buf_in_ready;
  wire rsp_take;

  assign rsp_take        = mem_rdata_valid & buf_in_ready;
  assign mem_rdata_ready = buf_in_ready;

  // A reply still in flight at frame end is dropped, not buffered
  always @(posedge clk) begin
    if (!reset_n) begin
      mem_req     <= 1'b0;
      pending_reg <= 1'b0;
      drop_reg    <= 1'b0;
    end else if (ce) begin
      mem_req <= fetch_reg & ~cs_rise & ~pending_reg & ~mem_req & buf_in_ready
                 & ~drop_reg;
      if (mem_req)
        pending_reg <= 1'b1;
      else if (rsp_take)
        pending_reg <= 1'b0;
      if (cs_rise && (pending_reg || mem_req))
        drop_reg <= 1'b1;
      else if (rsp_take)
        drop_reg <= 1'b0;
    end
  end

  byte_skid_buffer #(
    .WIDTH (8)
  ) u_rd_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .flush     (buf_flush),
    .in_valid  (mem_rdata_valid & ~drop_reg),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rdata),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

endmodule // flash_cmd_seq

/* rtl/flash_seq_defs.vh */
// Shared constants of the serial flash command sequencer
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH

// ***************************************************************
// Command opcodes
// ***************************************************************
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_STATUS_READ_LO   8'h05
`define OP_STATUS_READ_HI   8'h35
`define OP_VOLATILE_ENABLE  8'h50
`define OP_STATUS_WRITE     8'h01
`define OP_READ             8'h03
`define OP_FAST_READ        8'h0b
`define OP_DUAL_OUT_READ    8'h3b
`define OP_QUAD_OUT_READ    8'h6b
`define OP_DUAL_IO_READ     8'hbb

// ***************************************************************
// Status word bit positions
// ***************************************************************
`define SR_WIP              0
`define SR_WEL              1
`define SR_STATUS_PROTECT_LOWER             7
`define SR_STATUS_PROTECT_UPPER             8
`define SR_QE               9
`define SR_RESERVED         15
`define SR_NV_RESET         13'h0000
`define CRM_ENTER_CODE      2'h2

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_MHZ             50
`define NORMAL_READ_MAX_MHZ 50
`define STATUS_WRITE_US     5000
`define STATUS_WRITE_CYCLES (`STATUS_WRITE_US * `CLK_MHZ)

`endif
